// ===== design/temp_alarm_pkg.sv
/*
  Shared constants for the temperature alarm configuration block:
  register addresses, field positions, hysteresis codes, flag indices,
  sensing phases and the temperature scale.
  Assumes a 13-bit two's complement temperature word.
*/
package temp_alarm_pkg;

  // ***************************************************************
  // Register addresses
  // ***************************************************************
  localparam logic [7:0] ADDR_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_UPPER  = 8'h02;
  localparam logic [7:0] ADDR_LOWER  = 8'h03;
  localparam logic [7:0] ADDR_CRIT   = 8'h04;
  localparam logic [7:0] ADDR_TEMP   = 8'h05;

  // ***************************************************************
  // Field layout
  // ***************************************************************
  localparam int REG_W         = 16;
  localparam int TEMP_W        = 13;
  localparam int CFG_RSV_W     = 5;
  localparam int CFG_HYST_LO   = 9;
  localparam int CFG_HYST_HI   = 10;
  localparam int CFG_SHUTDOWN  = 8;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_WIN_LOCK  = 6;
  localparam int CFG_CTL_W     = 4;
  localparam logic [CFG_RSV_W-1:0] CFG_RSV_VALUE = 5'h00;
  localparam logic                 CFG_CLEAR_RD  = 1'b0;
  localparam logic [REG_W-1:0]     RD_UNMAPPED   = 16'h0000;

  // Alarm flag indices, also the order of bits 13..15 of the reading
  localparam int FLAG_BELOW = 0;
  localparam int FLAG_ABOVE = 1;
  localparam int FLAG_CRIT  = 2;
  localparam int NUM_FLAGS  = 3;

  // ***************************************************************
  // Hysteresis and temperature scale
  // ***************************************************************
  typedef enum logic [1:0] {
    HYST_OFF = 2'h0,
    HYST_1P5 = 2'h1,
    HYST_3   = 2'h2,
    HYST_6   = 2'h3
  } hyst_sel_t;

  localparam int TEMP_LSB_UC = 62500;
  localparam int HYST_1P5_UC = 1500000;
  localparam int HYST_3_UC   = 3000000;
  localparam int HYST_6_UC   = 6000000;

  // Sensing phase around shutdown
  typedef enum logic [3:0] {
    PH_NORMAL   = 4'h1,
    PH_SHUTDOWN = 4'h2,
    PH_FIRST    = 4'h4,
    PH_SECOND   = 4'h8
  } phase_t;

endpackage

// ===== design/threshold_flag.sv
/*
  One alarm threshold comparison with hysteresis, combinational.
  Assumes the caller holds the previous flag and samples the result
  once per conversion.
*/
`timescale 1ns/10ps
module threshold_flag #(
  parameter bit IS_BELOW = 1'b0
) (
  // Measurement and threshold
  input  wire logic [temp_alarm_pkg::TEMP_W-1:0] temp,
  input  wire logic [temp_alarm_pkg::TEMP_W-1:0] limit,
  input  wire logic [temp_alarm_pkg::TEMP_W-1:0] hyst,
  // Flag state
  input  wire logic                              flag,
  output      logic                              next_flag
);

  // One extra bit so limit minus hysteresis cannot wrap
  logic signed [temp_alarm_pkg::TEMP_W:0] t_ext;
  logic signed [temp_alarm_pkg::TEMP_W:0] l_ext;
  logic signed [temp_alarm_pkg::TEMP_W:0] lh_ext;

  assign t_ext  = {temp[temp_alarm_pkg::TEMP_W-1], temp};
  assign l_ext  = {limit[temp_alarm_pkg::TEMP_W-1], limit};
  assign lh_ext = l_ext - $signed({1'b0, hyst});

  // Set above flag falls back only at or below the lowered threshold; set below flag falls back at the limit
  always_comb
  begin
    if (IS_BELOW)
      next_flag = flag ? (t_ext < l_ext) : (t_ext <= lh_ext);
    else
      next_flag = flag ? (t_ext > lh_ext) : (t_ext > l_ext);
  end

endmodule

// ===== design/config_write_filter.sv
/*
  Lock filtering of a configuration register write, combinational.
  Assumes the write strobe is already qualified by the address decode.
*/
`timescale 1ns/10ps
module config_write_filter (
  // Current values
  input  wire logic [1:0]                           cur_hyst,
  input  wire logic                                 cur_shutdown,
  input  wire logic                                 cur_crit_lock,
  input  wire logic                                 cur_win_lock,
  input  wire logic [temp_alarm_pkg::CFG_CTL_W-1:0] cur_ctl,
  // Write request
  input  wire logic                                 wr,
  input  wire logic [temp_alarm_pkg::REG_W-1:0]     wdata,
  // Filtered values
  output      logic [1:0]                           next_hyst,
  output      logic                                 next_shutdown,
  output      logic                                 next_crit_lock,
  output      logic                                 next_win_lock,
  output      logic [temp_alarm_pkg::CFG_CTL_W-1:0] next_ctl
);

  logic locked;

  assign locked = cur_crit_lock | cur_win_lock;

  // Locks only ever set; reset is the sole way back
  always_comb
  begin
    next_hyst      = cur_hyst;
    next_shutdown  = cur_shutdown;
    next_crit_lock = cur_crit_lock;
    next_win_lock  = cur_win_lock;
    next_ctl       = cur_ctl;
    if (wr)
    begin
      if (!locked)
        next_hyst = wdata[temp_alarm_pkg::CFG_HYST_HI:temp_alarm_pkg::CFG_HYST_LO];
      if (!wdata[temp_alarm_pkg::CFG_SHUTDOWN] || !locked)
        next_shutdown = wdata[temp_alarm_pkg::CFG_SHUTDOWN];
      next_crit_lock = cur_crit_lock | wdata[temp_alarm_pkg::CFG_CRIT_LOCK];
      next_win_lock  = cur_win_lock | wdata[temp_alarm_pkg::CFG_WIN_LOCK];
      next_ctl       = wdata[temp_alarm_pkg::CFG_CTL_W-1:0];
    end
  end

endmodule

// ===== design/temp_alarm_config.sv
/*
  Configuration, alarm window and shutdown logic of a temperature
  sensor: register file, limit locks, hysteresis comparison and the
  alert level handed to the output pin driver.
  Assumes register accesses arrive as one-cycle strobes from the serial
  interface logic, and each finished conversion as a one-cycle strobe
  with its result, all synchronous to clock.
*/
`timescale 1ns/10ps

module temp_alarm_config #(
  parameter int TEMP_LSB_UC = temp_alarm_pkg::TEMP_LSB_UC
) (
  // Clock and power-on reset
  input  wire logic                                clock,
  input  wire logic                                sys_rst,

  // Register access from the serial interface
  input  wire logic                                reg_wr_en,
  input  wire logic                                reg_rd_en,
  input  wire logic [7:0]                          reg_addr,
  input  wire logic [temp_alarm_pkg::REG_W-1:0]    reg_wdata,
  output      logic [temp_alarm_pkg::REG_W-1:0]    reg_rdata,
  output      logic                                reg_rvalid,

  // Converter
  input  wire logic                                conv_valid,
  input  wire logic [temp_alarm_pkg::TEMP_W-1:0]   conv_temp,
  output      logic                                sensor_enable,

  // Alert level to the pin driver
  output      logic                                alert_active
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  // Largest step stays below the positive range
  // Keeps limit minus hysteresis from wrapping
  localparam int HYST_MAX = (1 << (temp_alarm_pkg::TEMP_W - 1)) - 1;

  if (TEMP_LSB_UC <= 0 ||
      (temp_alarm_pkg::HYST_1P5_UC % TEMP_LSB_UC) != 0 ||
      (temp_alarm_pkg::HYST_6_UC / TEMP_LSB_UC) > HYST_MAX)
  begin : g_bad_lsb
    $error("TEMP_LSB_UC must divide the hysteresis steps and keep them in range");
  end

  // ***************************************************************
  // Hysteresis in temperature counts
  // ***************************************************************
  // Whole LSB counts only
  // Uneven steps are refused above, never rounded
  localparam logic [temp_alarm_pkg::TEMP_W-1:0] HYST_1P5_CNT =
    temp_alarm_pkg::TEMP_W'(temp_alarm_pkg::HYST_1P5_UC / TEMP_LSB_UC);
  localparam logic [temp_alarm_pkg::TEMP_W-1:0] HYST_3_CNT =
    temp_alarm_pkg::TEMP_W'(temp_alarm_pkg::HYST_3_UC / TEMP_LSB_UC);
  localparam logic [temp_alarm_pkg::TEMP_W-1:0] HYST_6_CNT =
    temp_alarm_pkg::TEMP_W'(temp_alarm_pkg::HYST_6_UC / TEMP_LSB_UC);
  localparam logic [temp_alarm_pkg::TEMP_W-1:0] HYST_0_CNT = '0;

  // ***************************************************************
  // State
  // ***************************************************************
  // Every flop of the block in one word
  // Reset gives the power-on defaults
  typedef struct packed {
    logic [1:0]                           hyst;
    logic                                 shutdown;
    logic                                 crit_lock;
    logic                                 win_lock;
    logic [temp_alarm_pkg::CFG_CTL_W-1:0] ctl;
    logic [temp_alarm_pkg::TEMP_W-1:0]    upper;
    logic [temp_alarm_pkg::TEMP_W-1:0]    lower;
    logic [temp_alarm_pkg::TEMP_W-1:0]    crit;
    logic [temp_alarm_pkg::TEMP_W-1:0]    temp;
    logic [temp_alarm_pkg::NUM_FLAGS-1:0] flags;
    logic                                 alert;
    temp_alarm_pkg::phase_t               phase;
    logic [temp_alarm_pkg::REG_W-1:0]     rdata;
    logic                                 rvalid;
    logic                                 sensor_en;
  } state_t;

  state_t s;
  state_t next_s;

  // Filtered configuration write
  logic                                 cfg_wr;
  logic [1:0]                           next_hyst;
  logic                                 next_shutdown;
  logic                                 next_crit_lock;
  logic                                 next_win_lock;
  logic [temp_alarm_pkg::CFG_CTL_W-1:0] next_ctl;

  // Comparator plumbing
  logic [temp_alarm_pkg::TEMP_W-1:0]    hyst_cnt;
  logic [temp_alarm_pkg::TEMP_W-1:0]    limits [temp_alarm_pkg::NUM_FLAGS];
  logic [temp_alarm_pkg::NUM_FLAGS-1:0] next_flags;

  // ***************************************************************
  // Hysteresis decode
  // ***************************************************************
  // Decoded each cycle from the stored code
  // code to hysteresis amount
  always_comb
  begin
    case (temp_alarm_pkg::hyst_sel_t'(s.hyst))
      temp_alarm_pkg::HYST_OFF: hyst_cnt = HYST_0_CNT;
      temp_alarm_pkg::HYST_1P5: hyst_cnt = HYST_1P5_CNT;
      temp_alarm_pkg::HYST_3:   hyst_cnt = HYST_3_CNT;
      temp_alarm_pkg::HYST_6:   hyst_cnt = HYST_6_CNT;
      default:                  hyst_cnt = HYST_0_CNT;
    endcase
  end

  // ***************************************************************
  // Threshold comparators
  // ***************************************************************
  // Limits in force now, never the value being written this cycle
  // So a same-edge write races nothing
  assign limits[temp_alarm_pkg::FLAG_BELOW] = s.lower;
  assign limits[temp_alarm_pkg::FLAG_ABOVE] = s.upper;
  assign limits[temp_alarm_pkg::FLAG_CRIT]  = s.crit;

  // A set flag is the remembered trend
  // No separate direction register needed
  // upper and critical use the lowered threshold only once set; lower only while clear
  genvar gi;
  for (gi = 0; gi < temp_alarm_pkg::NUM_FLAGS; gi++)
  begin : g_flag
    threshold_flag #(
      .IS_BELOW (gi == temp_alarm_pkg::FLAG_BELOW)
    ) u_cmp (
      .temp      (conv_temp),
      .limit     (limits[gi]),
      .hyst      (hyst_cnt),
      .flag      (s.flags[gi]),
      .next_flag (next_flags[gi])
    );
  end

  // ***************************************************************
  // Configuration write filter
  // ***************************************************************
  // Only the configuration address reaches
  // The filter; other writes leave it alone
  assign cfg_wr = reg_wr_en && (reg_addr == temp_alarm_pkg::ADDR_CONFIG);

  config_write_filter u_cfg (
    .cur_hyst       (s.hyst),
    .cur_shutdown   (s.shutdown),
    .cur_crit_lock  (s.crit_lock),
    .cur_win_lock   (s.win_lock),
    .cur_ctl        (s.ctl),
    .wr             (cfg_wr),
    .wdata          (reg_wdata),
    .next_hyst      (next_hyst),
    .next_shutdown  (next_shutdown),
    .next_crit_lock (next_crit_lock),
    .next_win_lock  (next_win_lock),
    .next_ctl       (next_ctl)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb
  begin
    next_s        = s;
    // Valid pulses; data holds till the next read
    next_s.rvalid = 1'b0;

    // Register writes; limit writes stop at their lock
    // Config fields arrive lock-filtered
    next_s.hyst      = next_hyst;
    next_s.shutdown  = next_shutdown;
    next_s.crit_lock = next_crit_lock;
    next_s.win_lock  = next_win_lock;
    next_s.ctl       = next_ctl;

    if (reg_wr_en)
    begin
      case (reg_addr)
        temp_alarm_pkg::ADDR_UPPER:
        begin
          if (!s.win_lock)
            next_s.upper = reg_wdata[temp_alarm_pkg::TEMP_W-1:0];
        end

        temp_alarm_pkg::ADDR_LOWER:
        begin
          if (!s.win_lock)
            next_s.lower = reg_wdata[temp_alarm_pkg::TEMP_W-1:0];
        end

        temp_alarm_pkg::ADDR_CRIT:
        begin
          if (!s.crit_lock)
            next_s.crit = reg_wdata[temp_alarm_pkg::TEMP_W-1:0];
        end

        default:
        begin
          // Read-only and unmapped: no write
          next_s.upper = s.upper;
        end
      endcase
    end

    // Settings before this edge decide
    // A same-cycle write waits a result
    // one evaluation per finished conversion
    if (conv_valid && !s.shutdown)
    begin
      next_s.temp  = conv_temp;
      // flags cleared, so only lower is lowered
      next_s.flags = next_flags;
      // alert from the same hysteretic flags
      next_s.alert = |next_flags;
      // Counts the two results after an exit
      case (s.phase)
        temp_alarm_pkg::PH_FIRST:  next_s.phase = temp_alarm_pkg::PH_SECOND;
        temp_alarm_pkg::PH_SECOND: next_s.phase = temp_alarm_pkg::PH_NORMAL;
        default:                   next_s.phase = s.phase;
      endcase
    end

    // Entry freezes flags for read-back
    // Exit clears them, trend taken as rising
    // Shutdown edges override the conversion above
    if (!s.shutdown && next_shutdown)
    begin
      next_s.alert = 1'b0;
      next_s.phase = temp_alarm_pkg::PH_SHUTDOWN;
    end
    else if (s.shutdown && !next_shutdown)
    begin
      next_s.flags = '0;
      next_s.alert = 1'b0;
      next_s.phase = temp_alarm_pkg::PH_FIRST;
    end

    // Filtered value, so a refused set never stops it
    // converter runs while not shut down
    next_s.sensor_en = !next_shutdown;

    // Same-cycle write: read returns the old value
    // reads served the same in every phase
    if (reg_rd_en)
    begin
      next_s.rvalid = 1'b1;
      case (reg_addr)
        temp_alarm_pkg::ADDR_CONFIG:
          next_s.rdata = {temp_alarm_pkg::CFG_RSV_VALUE, s.hyst, s.shutdown,
                          s.crit_lock, s.win_lock, temp_alarm_pkg::CFG_CLEAR_RD,
                          s.alert, s.ctl};

        temp_alarm_pkg::ADDR_UPPER:
          next_s.rdata = {{(temp_alarm_pkg::REG_W - temp_alarm_pkg::TEMP_W){1'b0}},
                          s.upper};

        temp_alarm_pkg::ADDR_LOWER:
          next_s.rdata = {{(temp_alarm_pkg::REG_W - temp_alarm_pkg::TEMP_W){1'b0}},
                          s.lower};

        temp_alarm_pkg::ADDR_CRIT:
          next_s.rdata = {{(temp_alarm_pkg::REG_W - temp_alarm_pkg::TEMP_W){1'b0}},
                          s.crit};

        temp_alarm_pkg::ADDR_TEMP:
          // Flags above the reading, critical first
          next_s.rdata = {s.flags[temp_alarm_pkg::FLAG_CRIT],
                          s.flags[temp_alarm_pkg::FLAG_ABOVE],
                          s.flags[temp_alarm_pkg::FLAG_BELOW], s.temp};

        default:
          next_s.rdata = temp_alarm_pkg::RD_UNMAPPED;
      endcase
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  // Power-on reset is the only thing that releases the locks
  // Synchronous: one clock, no async path
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      // Locks, limits and flags back to zero
      s           <= '0;
      s.phase     <= temp_alarm_pkg::PH_NORMAL;
      s.sensor_en <= 1'b1;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ***************************************************************
  // Outputs, all straight from flops
  // ***************************************************************
  // Plain state bits: no decode glitch at the pin
  assign reg_rdata     = s.rdata;
  assign reg_rvalid    = s.rvalid;
  assign sensor_enable = s.sensor_en;
  assign alert_active  = s.alert;

endmodule

// ===== dv/temp_alarm_checker.sv
/*
  Port-level checker of the temperature alarm configuration block.
  Assumes it is bound to temp_alarm_config and sees its ports only.
*/
`timescale 1ns/10ps
module temp_alarm_checker #(
  parameter int TEMP_LSB_UC = 62500
) (
  // Clock and reset
  input wire logic                             clock,
  input wire logic                             sys_rst,
  // Register access
  input wire logic                             reg_wr_en,
  input wire logic                             reg_rd_en,
  input wire logic [7:0]                       reg_addr,
  input wire logic [temp_alarm_pkg::REG_W-1:0] reg_wdata,
  input wire logic [temp_alarm_pkg::REG_W-1:0] reg_rdata,
  input wire logic                             reg_rvalid,
  // Converter and alert
  input wire logic                             conv_valid,
  input wire logic [temp_alarm_pkg::TEMP_W-1:0] conv_temp,
  input wire logic                             sensor_enable,
  input wire logic                             alert_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  logic cfg_wr;
  logic lock_seen;

  // Config write decode
  assign cfg_wr = reg_wr_en && (reg_addr == temp_alarm_pkg::ADDR_CONFIG);

  // Lock state before each write; only power-on reset clears it
  always_ff @(posedge clock)
    if (sys_rst)
      lock_seen <= 1'b0;
    else if (cfg_wr && (reg_wdata[7] || reg_wdata[6]))
      lock_seen <= 1'b1;

  // ***************************************************************
  // Properties
  // ***************************************************************
  property p_read_answer;
    reg_rd_en |=> reg_rvalid;
  endproperty
  property p_no_spurious_valid;
    reg_rvalid |-> $past(reg_rd_en);
  endproperty
  property p_rdata_holds;
    !reg_rvalid |-> $stable(reg_rdata);
  endproperty
  property p_reserved_zero;
    reg_rvalid && ($past(reg_addr) == temp_alarm_pkg::ADDR_CONFIG) |-> reg_rdata[15:11] == 5'h00;
  endproperty
  property p_unmapped_zero;
    reg_rd_en && (reg_addr == 8'h00 || reg_addr > 8'h05) |=> reg_rdata == 16'h0000;
  endproperty
  property p_enter_shutdown;
    cfg_wr && reg_wdata[8] && !lock_seen |=> !sensor_enable && !alert_active;
  endproperty
  property p_locked_no_shutdown;
    cfg_wr && lock_seen && sensor_enable |=> sensor_enable;
  endproperty
  property p_quiet_in_shutdown;
    !sensor_enable |-> !alert_active;
  endproperty
  property p_exit_shutdown;
    cfg_wr && !reg_wdata[8] && !sensor_enable |=> sensor_enable && !alert_active;
  endproperty
  property p_alert_cause;
    $changed(alert_active) |-> $past(conv_valid) || $past(cfg_wr);
  endproperty

  a_read_answer:        assert property (p_read_answer) else $error("read not answered");
  a_no_spurious_valid:  assert property (p_no_spurious_valid) else $error("stray read valid");
  a_rdata_holds:        assert property (p_rdata_holds) else $error("read data moved");
  a_reserved_zero:      assert property (p_reserved_zero) else $error("reserved bits set");
  a_unmapped_zero:      assert property (p_unmapped_zero) else $error("unmapped read nonzero");
  a_enter_shutdown:     assert property (p_enter_shutdown) else $error("shutdown entry wrong");
  a_locked_no_shutdown: assert property (p_locked_no_shutdown) else $error("locked shutdown taken");
  a_quiet_in_shutdown:  assert property (p_quiet_in_shutdown) else $error("alert in shutdown");
  a_exit_shutdown:      assert property (p_exit_shutdown) else $error("shutdown exit wrong");
  a_alert_cause:        assert property (p_alert_cause) else $error("alert moved uncaused");

  // Main scenarios reached
  c_shutdown: cover property (cfg_wr && reg_wdata[8] && !lock_seen);
  c_alert:    cover property ($rose(alert_active));
  c_locked:   cover property (cfg_wr && lock_seen);
endmodule

bind temp_alarm_config temp_alarm_checker #(.TEMP_LSB_UC(TEMP_LSB_UC)) i_temp_alarm_checker (
  .clock(clock), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .conv_valid(conv_valid), .conv_temp(conv_temp),
  .sensor_enable(sensor_enable), .alert_active(alert_active)
);

// ===== dv/reg_host.sv
/*
  Behavioural model of the serial management host that issues
  register accesses as one-cycle strobes.
  Assumes the bench calls its tasks after reset has been released.
*/
`timescale 1ns/10ps
module reg_host (
  // Clock
  input  wire logic                             clock,
  // Register access
  output      logic                             reg_wr_en,
  output      logic                             reg_rd_en,
  output      logic [7:0]                       reg_addr,
  output      logic [temp_alarm_pkg::REG_W-1:0] reg_wdata,
  input  wire logic [temp_alarm_pkg::REG_W-1:0] reg_rdata,
  input  wire logic                             reg_rvalid
);
  initial
  begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
  end

  // One write strobe; data idles inverted so stale values never match
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= {5'h00, d[10:0]};
    @(posedge clock);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~{5'h00, d[10:0]};
    #1;
  endtask

  // One read strobe; answer taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    #1;
    ok = (reg_rvalid === 1'b1);
    d  = reg_rdata;
  endtask
endmodule

// ===== dv/tb_top.sv
/*
  Self-checking bench of the temperature alarm configuration block.
  Assumes the host model drives register strobes and this bench the
  converter strobe; expectations come from the limits set here.
*/
`timescale 1ns/10ps
module tb_top;
  typedef struct packed {
    logic [1:0]  h;
    logic [12:0] t;
    logic [2:0]  f;
  } row_t;

  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        conv_valid = 1'b0;
  logic [12:0] conv_temp = 13'h0000;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        sensor_enable;
  logic        alert_active;
  int          err_count = 0;
  int          compares = 0;
  // Limits: upper 25, lower 10, critical 80 degrees
  row_t        rows[18] = '{
    '{2'h0, 13'h0c8, 3'h0}, '{2'h0, 13'h191, 3'h2}, '{2'h0, 13'h190, 3'h0},
    '{2'h1, 13'h191, 3'h2}, '{2'h1, 13'h179, 3'h2}, '{2'h1, 13'h178, 3'h0},
    '{2'h2, 13'h191, 3'h2}, '{2'h2, 13'h161, 3'h2}, '{2'h2, 13'h160, 3'h0},
    '{2'h3, 13'h191, 3'h2}, '{2'h3, 13'h131, 3'h2}, '{2'h3, 13'h130, 3'h0},
    '{2'h3, 13'h0a0, 3'h0}, '{2'h3, 13'h041, 3'h0}, '{2'h3, 13'h040, 3'h1},
    '{2'h3, 13'h09f, 3'h1}, '{2'h3, 13'h0a0, 3'h0}, '{2'h0, 13'h501, 3'h6}};

  // 125 MHz clock
  always #4 clock = ~clock;

  reg_host i_reg_host (
    .clock(clock), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  temp_alarm_config i_temp_alarm_config (
    .clock(clock), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .conv_valid(conv_valid), .conv_temp(conv_temp),
    .sensor_enable(sensor_enable), .alert_active(alert_active)
  );

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Read and compare; bits clear in mask are ignored
  task automatic rchk(input string name, input logic [7:0] a, input logic [15:0] exp,
                      input logic [15:0] mask);
    logic [15:0] d;
    logic        ok;
    i_reg_host.rd(a, d, ok);
    chk({name, " valid"}, {15'h0000, ok}, 16'h0001);
    chk(name, d & mask, exp);
  endtask

  task automatic conv(input logic [12:0] t);
    @(posedge clock);
    conv_valid <= 1'b1;
    conv_temp  <= t;
    @(posedge clock);
    conv_valid <= 1'b0;
    conv_temp  <= ~t;
  endtask

  task automatic do_reset();
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
  endtask

  task automatic final_report();
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    err_count++;
    final_report();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    do_reset();
    chk("sensor_enable", {15'h0, sensor_enable}, 16'h0001);
    rchk("config reset", temp_alarm_pkg::ADDR_CONFIG, 16'h0000, 16'hffff);
    rchk("unmapped", 8'h10, 16'h0000, 16'hffff);
    i_reg_host.wr(temp_alarm_pkg::ADDR_UPPER, 16'h0190);
    i_reg_host.wr(temp_alarm_pkg::ADDR_LOWER, 16'h00a0);
    i_reg_host.wr(temp_alarm_pkg::ADDR_CRIT, 16'h0500);
    $display("Test reset done");

    // Window flags for every hysteresis code
    foreach (rows[i])
    begin
      i_reg_host.wr(temp_alarm_pkg::ADDR_CONFIG, {5'h00, rows[i].h, 9'h000});
      conv(rows[i].t);
      rchk("temperature", temp_alarm_pkg::ADDR_TEMP, {rows[i].f, rows[i].t}, 16'hffff);
      chk("alert", {15'h0, alert_active}, {15'h0, |rows[i].f});
    end
    $display("Test window table done");

    // Shutdown freezes data and silences alert
    i_reg_host.wr(temp_alarm_pkg::ADDR_CONFIG, 16'h0100);
    chk("sd enable", {15'h0, sensor_enable}, 16'h0000);
    chk("sd alert", {15'h0, alert_active}, 16'h0000);
    conv(13'h0c8);
    rchk("sd temp", temp_alarm_pkg::ADDR_TEMP, 16'hc501, 16'hffff);
    rchk("sd config", temp_alarm_pkg::ADDR_CONFIG, 16'h0100, 16'hffff);
    i_reg_host.wr(temp_alarm_pkg::ADDR_CONFIG, 16'h0600);
    chk("exit enable", {15'h0, sensor_enable}, 16'h0001);
    rchk("exit flags", temp_alarm_pkg::ADDR_TEMP, 16'h0501, 16'hffff);
    repeat (4) @(posedge clock);
    chk("exit alert", {15'h0, alert_active}, 16'h0000);
    conv(13'h064);
    rchk("first conv", temp_alarm_pkg::ADDR_TEMP, 16'h0064, 16'hffff);
    conv(13'h191);
    rchk("second conv", temp_alarm_pkg::ADDR_TEMP, 16'h4191, 16'hffff);
    chk("second alert", {15'h0, alert_active}, 16'h0001);
    $display("Test shutdown done");

    // Locks hold hysteresis, shutdown and limits
    i_reg_host.wr(temp_alarm_pkg::ADDR_CONFIG, 16'h0400);
    i_reg_host.wr(temp_alarm_pkg::ADDR_CONFIG, 16'h0440);
    i_reg_host.wr(temp_alarm_pkg::ADDR_CONFIG, 16'h030a);
    chk("lock enable", {15'h0, sensor_enable}, 16'h0001);
    rchk("lock config", temp_alarm_pkg::ADDR_CONFIG, 16'h044a, 16'hffef);
    i_reg_host.wr(temp_alarm_pkg::ADDR_UPPER, 16'h0050);
    rchk("locked upper", temp_alarm_pkg::ADDR_UPPER, 16'h0190, 16'hffff);
    i_reg_host.wr(temp_alarm_pkg::ADDR_CONFIG, 16'h0080);
    rchk("both locks", temp_alarm_pkg::ADDR_CONFIG, 16'h04c0, 16'hffef);
    i_reg_host.wr(temp_alarm_pkg::ADDR_CRIT, 16'h0010);
    rchk("locked crit", temp_alarm_pkg::ADDR_CRIT, 16'h0500, 16'hffff);
    do_reset();
    rchk("unlocked", temp_alarm_pkg::ADDR_CONFIG, 16'h0000, 16'hffff);
    rchk("upper reset", temp_alarm_pkg::ADDR_UPPER, 16'h0000, 16'hffff);
    chk("reset alert", {15'h0, alert_active}, 16'h0000);
    $display("Test locks done");
    final_report();
  end
endmodule
